// ==== hbs_pkg.sv ====
`default_nettype none
package hbs_pkg;

  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  // one millisecond in clock cycles
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // ******************************************************************
  // frame identifiers and command bytes
  // ******************************************************************
  localparam logic [10:0] ID_NMT = 11'h000;
  localparam logic [10:0] ID_SDO_REQ = 11'h600;
  localparam logic [10:0] ID_SDO_RSP = 11'h580;
  localparam logic [10:0] ID_HBEAT = 11'h700;
  localparam logic [7:0] SDO_WRITE = 8'h23;
  localparam logic [7:0] SDO_READ = 8'h40;
  localparam logic [7:0] SDO_READ_RSP = 8'h43;
  localparam logic [7:0] SDO_WRITE_ACK = 8'h60;
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_STOP = 8'h02;
  localparam logic [7:0] NMT_PREOP = 8'h80;
  localparam logic [7:0] NMT_RESET_NODE = 8'h81;
  localparam logic [7:0] NMT_RESET_COMM = 8'h82;

  // ******************************************************************
  // object dictionary entries
  // ******************************************************************
  localparam logic [15:0] OFS_CONSUMER_HEARTBEAT_WATCH = 16'h1016;
  localparam logic [15:0] OFS_PRODUCER_HEARTBEAT_PERIOD = 16'h1017;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_ENTRY = 8'h01;
  localparam logic [7:0] CONSUMER_COUNT = 8'h01;
  localparam logic [15:0] PERIOD_RST = 16'h0000;

  // ******************************************************************
  // heartbeat telegram contents
  // ******************************************************************
  localparam logic [7:0] CODE_BOOTUP = 8'h00;
  localparam logic [7:0] CODE_STOPPED = 8'h04;
  localparam logic [7:0] CODE_OPER = 8'h05;
  localparam logic [7:0] CODE_PREOP = 8'h7F;
  localparam logic [7:0] HB_BYTE5 = 8'h01;

  typedef enum logic [3:0] {
    NS_BOOT = 4'b0001,
    NS_PREOP = 4'b0010,
    NS_OPER = 4'b0100,
    NS_STOP = 4'b1000
  } hbs_nmt_t;

  typedef struct packed {
    hbs_nmt_t st;
    logic [7:0] code;
    logic [6:0] node;
    logic [15:0] div;
    logic [15:0] prod_cnt;
    logic hb_pend;
    logic boot_pend;
    logic cons_act;
    logic [15:0] cons_time;
    logic [6:0] cons_node;
    logic [15:0] cons_cnt;
    logic rsp_pend;
    logic [63:0] rsp_data;
    logic tx_valid;
    logic [10:0] tx_id;
    logic [63:0] tx_data;
    logic safe;
  } hbs_state_t;

  // base identifier plus node number
  function automatic logic [10:0] hbs_cob(input logic [10:0] base,
                                          input logic [6:0] node);
    hbs_cob = base + {4'h0, node};
  endfunction : hbs_cob

  // state code carried in the heartbeat
  function automatic logic [7:0] hbs_code(input hbs_nmt_t s);
    case (s)
      NS_OPER: hbs_code = CODE_OPER;
      NS_STOP: hbs_code = CODE_STOPPED;
      NS_PREOP: hbs_code = CODE_PREOP;
      default: hbs_code = CODE_BOOTUP;
    endcase
  endfunction : hbs_code

endpackage : hbs_pkg
`default_nettype wire

// ==== hbs_store.sv ====
`timescale 1ns/1ps
`default_nettype none
// holds the producer period with no reset, so a reset keeps it
module hbs_store
  import hbs_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic wr_en, // store a new period
  input wire logic [15:0] wr_data, // period to store
  output logic [15:0] rd_q // stored period, registered
);
  // initial value stands in for the non-volatile power-up content
  logic [15:0] mem_q = PERIOD_RST;

  // reset-free on purpose: survives RSTN
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q <= wr_data;
    end
    rd_q <= mem_q;
  end
endmodule : hbs_store
`default_nettype wire

// ==== hbs_heartbeat.sv ====
`timescale 1ns/1ps
`default_nettype none
module hbs_heartbeat
  import hbs_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES // cycles per millisecond
)
(
  input wire logic CLK, // 40 MHz clock
  input wire logic RSTN, // async reset, active low
  input wire logic [6:0] NODE_ID, // node number, caught at boot
  input wire logic RX_VALID, // received frame strobe
  input wire logic [10:0] RX_ID, // received identifier
  input wire logic [63:0] RX_DATA, // received bytes, D1 in [7:0]
  input wire logic TX_READY, // controller takes the frame
  output logic TX_VALID, // frame to send
  output logic [10:0] TX_ID, // identifier to send
  output logic [63:0] TX_DATA, // bytes to send, D1 in [7:0]
  output logic SAFE_RESET, // pulse: outputs to default state
  output logic [7:0] NMT_STATE, // current state code
  output logic CONSUMER_ACTIVE // monitoring enabled
);

  // ****************************************************************
  // frame decode
  // ****************************************************************
  hbs_state_t q, d;
  logic [15:0] period;
  logic [7:0] cmd, sub;
  logic [15:0] obj, val;
  logic tick, is_sdo, sdo_ok, wr_cons, wr_prod, rd_ok, hb_seen;

  assign cmd = RX_DATA[7:0];
  assign obj = RX_DATA[23:8];
  assign sub = RX_DATA[31:24];
  assign val = RX_DATA[47:32];
  assign tick = (q.div == 16'(TICK_CYCLES - 1));
  assign is_sdo = RX_VALID && (RX_ID == hbs_cob(ID_SDO_REQ, q.node));
  assign sdo_ok = is_sdo && (q.st == NS_PREOP || q.st == NS_OPER);
  assign wr_cons = sdo_ok && cmd == SDO_WRITE
                   && obj == OFS_CONSUMER_HEARTBEAT_WATCH && sub == SUB_ENTRY;
  assign wr_prod = sdo_ok && cmd == SDO_WRITE
                   && obj == OFS_PRODUCER_HEARTBEAT_PERIOD && sub == SUB_COUNT;
  assign rd_ok = sdo_ok && cmd == SDO_READ
                 && ((obj == OFS_CONSUMER_HEARTBEAT_WATCH && sub <= SUB_ENTRY)
                 || (obj == OFS_PRODUCER_HEARTBEAT_PERIOD && sub == SUB_COUNT));
  assign hb_seen = RX_VALID && (RX_ID == hbs_cob(ID_HBEAT, q.cons_node));

  // period kept outside the reset domain
  hbs_store u_store (
    .clk(CLK),
    .wr_en(wr_prod),
    .wr_data(val),
    .rd_q(period)
  );

  // node reset: keep period, node, consumer settings and any frame in flight; restart state, monitor, pending flags and producer count
  function automatic hbs_state_t fallback(input hbs_state_t s);
    hbs_state_t r;
    r = s;
    r.safe = 1'b1;
    r.st = NS_PREOP;
    r.boot_pend = 1'b1;
    r.cons_act = 1'b0;
    r.rsp_pend = 1'b0;
    r.hb_pend = 1'b0;
    r.prod_cnt = 16'h0000;
    fallback = r;
  endfunction : fallback

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    d = q;
    d.safe = 1'b0;
    d.div = tick ? 16'h0000 : q.div + 16'h0001;
    if (q.tx_valid && TX_READY)
    begin
      d.tx_valid = 1'b0;
    end
    // strap caught one cycle after release
    if (q.st == NS_BOOT)
    begin
      d.node = NODE_ID;
      d.st = NS_PREOP;
    end
    // consumer configuration and replies
    if (wr_cons)
    begin
      if (val == 16'h0000)
      begin
        d.cons_act = 1'b0;
      end
      else
      begin
        d.cons_act = 1'b1;
      end
      d.cons_time = val;
      d.cons_node = RX_DATA[54:48];
      d.cons_cnt = 16'h0000;
    end
    if (wr_prod)
    begin
      d.prod_cnt = 16'h0000;
      d.hb_pend = 1'b0;
    end
    if (wr_cons || wr_prod)
    begin
      d.rsp_pend = 1'b1;
      d.rsp_data = {32'h0, sub, obj, SDO_WRITE_ACK};
    end
    else if (rd_ok)
    begin
      d.rsp_pend = 1'b1;
      if (obj == OFS_PRODUCER_HEARTBEAT_PERIOD)
      begin
        d.rsp_data = {16'h0, period, sub, obj, SDO_READ_RSP};
      end
      else if (sub == SUB_COUNT)
      begin
        d.rsp_data = {24'h0, CONSUMER_COUNT, sub, obj, SDO_READ_RSP};
      end
      else
      begin
        d.rsp_data = {8'h0, 1'b0, q.cons_node, q.cons_time, sub, obj,
                      SDO_READ_RSP};
      end
    end
    if (q.cons_act && !wr_cons)
    begin
      if (hb_seen)
      begin
        d.cons_cnt = 16'h0000;
      end
      else if (tick)
      begin
        d.cons_cnt = q.cons_cnt + 16'h0001;
        if (q.cons_cnt + 16'h0001 >= q.cons_time)
        begin
          d = fallback(d);
        end
      end
    end
    // network management, addressed or broadcast
    if (RX_VALID && RX_ID == ID_NMT && q.st != NS_BOOT
        && (RX_DATA[15:8] == 8'h00 || RX_DATA[15:8] == {1'b0, q.node}))
    begin
      case (cmd)
        NMT_START: d.st = NS_OPER;
        NMT_STOP: d.st = NS_STOP;
        NMT_PREOP: d.st = NS_PREOP;
        NMT_RESET_NODE: d = fallback(d);
        NMT_RESET_COMM: d = fallback(d);
        default: d.st = d.st;
      endcase
    end
    if (period == 16'h0000)
    begin
      d.prod_cnt = 16'h0000;
      d.hb_pend = 1'b0;
    end
    // runs in every state after boot
    else if (tick && q.st != NS_BOOT && !wr_prod)
    begin
      if (q.prod_cnt + 16'h0001 >= period)
      begin
        d.prod_cnt = 16'h0000;
        d.hb_pend = 1'b1;
      end
      else
      begin
        d.prod_cnt = q.prod_cnt + 16'h0001;
      end
    end
    d.code = hbs_code(d.st);
    // transmit, bootup first; one idle cycle between frames
    if (!q.tx_valid)
    begin
      // node number is only valid once the boot cycle has latched it
      if (q.boot_pend && q.st != NS_BOOT)
      begin
        d.boot_pend = 1'b0;
        d.tx_valid = 1'b1;
        d.tx_id = hbs_cob(ID_HBEAT, q.node);
        d.tx_data = 64'h0;
      end
      else if (q.rsp_pend)
      begin
        d.rsp_pend = 1'b0;
        d.tx_valid = 1'b1;
        d.tx_id = hbs_cob(ID_SDO_RSP, q.node);
        d.tx_data = q.rsp_data;
      end
      else if (q.hb_pend && period != 16'h0000)
      begin
        d.hb_pend = 1'b0;
        d.tx_valid = 1'b1;
        d.tx_id = hbs_cob(ID_HBEAT, q.node);
        d.tx_data = {24'h0, HB_BYTE5, 24'h0, q.code};
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      q <= '0;
      q.st <= NS_BOOT;
      q.boot_pend <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign TX_VALID = q.tx_valid;
  assign TX_ID = q.tx_id;
  assign TX_DATA = q.tx_data;
  assign SAFE_RESET = q.safe;
  assign NMT_STATE = q.code;
  assign CONSUMER_ACTIVE = q.cons_act;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_hb_off;
    @(posedge CLK) disable iff (!RSTN)
    $rose(q.tx_valid) && q.tx_data[39:32] == HB_BYTE5
      && q.tx_id == hbs_cob(ID_HBEAT, q.node)
      |-> $past(period) != 16'h0000;
  endproperty
  a_hb_off: assert property (p_hb_off) else $error("beat with zero period");

  property p_hb_state;
    @(posedge CLK) disable iff (!RSTN)
    !q.tx_valid && q.hb_pend && !q.boot_pend && !q.rsp_pend
      && period != 16'h0000 |=> q.tx_valid && q.tx_data[7:0] != CODE_BOOTUP;
  endproperty
  a_hb_state: assert property (p_hb_state) else $error("beat not sent");

  property p_keep;
    @(posedge CLK) disable iff (!RSTN)
    wr_prod |-> ##2 period == $past(val, 2);
  endproperty
  a_keep: assert property (p_keep) else $error("period not stored");

  property p_hb_frame;
    @(posedge CLK) disable iff (!RSTN)
    $rose(q.tx_valid) && q.tx_data[39:32] == HB_BYTE5
      && q.tx_id != hbs_cob(ID_SDO_RSP, q.node)
      |-> q.tx_id == hbs_cob(ID_HBEAT, q.node)
      && q.tx_data[7:0] == $past(q.code) && q.tx_data[63:40] == 24'h0;
  endproperty
  a_hb_frame: assert property (p_hb_frame) else $error("bad beat frame");

  property p_boot;
    @(posedge CLK) disable iff (!RSTN)
    $fell(q.boot_pend) |-> q.tx_valid && q.tx_data == 64'h0
      && q.tx_id == hbs_cob(ID_HBEAT, q.node);
  endproperty
  a_boot: assert property (p_boot) else $error("bad bootup frame");

  property p_off;
    @(posedge CLK) disable iff (!RSTN)
    wr_cons && val == 16'h0000 |=> !q.cons_act;
  endproperty
  a_off: assert property (p_off) else $error("monitor still on");

  property p_act;
    @(posedge CLK) disable iff (!RSTN)
    $rose(q.cons_act) |-> $past(q.st) == NS_PREOP || $past(q.st) == NS_OPER;
  endproperty
  a_act: assert property (p_act) else $error("activated in bad state");

  property p_timeout;
    @(posedge CLK) disable iff (!RSTN)
    q.cons_act && tick && !hb_seen && !wr_cons
      && q.cons_cnt + 16'h0001 >= q.cons_time |=> q.safe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no timeout reset");

  property p_after;
    @(posedge CLK) disable iff (!RSTN)
    q.safe |-> (!q.cons_act && q.st == NS_PREOP)
      ##1 (q.tx_valid || q.boot_pend);
  endproperty
  a_after: assert property (p_after) else $error("bad fallback");

  property p_stop;
    @(posedge CLK) disable iff (!RSTN)
    q.st == NS_STOP && is_sdo && !q.rsp_pend |=> !q.rsp_pend;
  endproperty
  a_stop: assert property (p_stop) else $error("sdo taken in stop");

  property p_ack;
    @(posedge CLK) disable iff (!RSTN)
    (wr_cons || wr_prod || rd_ok) && !q.safe && !q.tx_valid
      && !q.boot_pend && !q.hb_pend |=> ##[1:2] q.tx_valid
      && q.tx_id == hbs_cob(ID_SDO_RSP, q.node);
  endproperty
  a_ack: assert property (p_ack) else $error("sdo not answered");

  c_boot: cover property (@(posedge CLK) disable iff (!RSTN) $fell(q.boot_pend));
  c_beat: cover property (@(posedge CLK) disable iff (!RSTN)
    $rose(q.tx_valid) && q.tx_data[39:32] == HB_BYTE5
    && q.tx_id == hbs_cob(ID_HBEAT, q.node));
  c_tmo: cover property (@(posedge CLK) disable iff (!RSTN) q.safe);
  c_read: cover property (@(posedge CLK) disable iff (!RSTN) rd_ok);

endmodule : hbs_heartbeat
`default_nettype wire

// ==== hbs_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// bus master model
// ****************
module hbs_master
  import hbs_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic slow, // take frames one edge in four
  input wire logic tx_valid, // frame offered
  input wire logic [10:0] tx_id, // offered id
  input wire logic [63:0] tx_data, // offered bytes
  output logic tx_ready, // frame taken on this edge
  output logic rx_valid, // frame strobe to device
  output logic [10:0] rx_id, // id to device
  output logic [63:0] rx_data, // bytes to device
  output logic got, // a frame was taken
  output logic [10:0] got_id, // id taken
  output logic [63:0] got_data // bytes taken
);
  logic [1:0] stall = 2'h0;

  // quiet bus at start
  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_id = 11'h7FF;
    rx_data = 64'h0;
    got = 1'b0;
    got_id = 11'h000;
    got_data = 64'h0;
  end

  // frame to device
  // lines are inverted after release so stale data never looks valid
  task automatic send(input logic [10:0] id, input logic [63:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_data <= ~d;
  endtask : send

  // a slow master stalls, so replies queue behind the transmitter
  always @(posedge clk)
  begin
    stall <= stall + 2'h1;
    tx_ready <= !slow || stall == 2'h3;
    got <= tx_valid && tx_ready;
    got_id <= tx_id;
    got_data <= tx_data;
  end

endmodule : hbs_master
`default_nettype wire

// ==== hbs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********************
// heartbeat bench
// ********************
module testbench
  import hbs_pkg::*;
();
  localparam int TK = 4;
  localparam logic [15:0] PIX = OFS_PRODUCER_HEARTBEAT_PERIOD;
  localparam logic [15:0] CIX = OFS_CONSUMER_HEARTBEAT_WATCH;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic slow = 1'b0;
  logic [6:0] node = 7'h02;
  logic [6:0] wn;
  logic [15:0] per;
  logic [15:0] tmo;
  logic [7:0] exp_code = CODE_PREOP;
  logic beats_on = 1'b0;
  logic [74:0] exp_q[$];
  int fail_count = 0;
  int samples_checked = 0;
  int hb_seen = 0;
  int safe_seen = 0;
  logic rx_valid, tx_ready, tx_valid, safe_reset, cons_act, got;
  logic [10:0] rx_id, tx_id, got_id, hb_id;
  logic [63:0] rx_data, tx_data, got_data;
  logic [74:0] hb_exp;
  logic [7:0] nmt_state;
  assign hb_id = ID_HBEAT + {4'h0, node};
  assign hb_exp = {hb_id, 24'h0, HB_BYTE5, 24'h0, exp_code};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  hbs_heartbeat #(.TICK_CYCLES(TK)) hbs_heartbeat_i (
    .CLK(clk), .RSTN(rstn), .NODE_ID(node), .RX_VALID(rx_valid),
    .RX_ID(rx_id), .RX_DATA(rx_data), .TX_READY(tx_ready),
    .TX_VALID(tx_valid), .TX_ID(tx_id), .TX_DATA(tx_data),
    .SAFE_RESET(safe_reset), .NMT_STATE(nmt_state),
    .CONSUMER_ACTIVE(cons_act)
  );
  hbs_master hbs_master_i (
    .clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_id(tx_id),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_id(rx_id), .rx_data(rx_data), .got(got), .got_id(got_id),
    .got_data(got_data)
  );

  task automatic check(input string what, input logic [74:0] seen,
                       input logic [74:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin

  // bounded wait until every noted frame has shown up
  task automatic wait_q();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 300)
    begin
      check("reply wait", 75'h1, 75'h0);
      test_done();
    end
  endtask : wait_q

  task automatic sdo(input logic [7:0] cmd, input logic [15:0] idx,
                     input logic [7:0] sub, input logic [23:0] val,
                     input logic [23:0] rv, input logic ack);
    if (ack)
      exp_q.push_back({ID_SDO_RSP + {4'h0, node}, 8'h00, rv, sub, idx,
                       cmd == SDO_WRITE ? SDO_WRITE_ACK : SDO_READ_RSP});
    hbs_master_i.send(ID_SDO_REQ + {4'h0, node},
                      {8'h00, val, sub, idx, cmd});
    wait_q();
    repeat (6) @(negedge clk);
  endtask : sdo

  // command lands just after a beat, so no beat straddles the change
  task automatic nmt(input logic [7:0] cmd, input logic [7:0] code);
    int n;
    n = hb_seen;
    repeat (40) if (beats_on && hb_seen == n) @(negedge clk);
    hbs_master_i.send(ID_NMT, {48'h0, 1'b0, node, cmd});
    exp_code = code;
    repeat (2) @(negedge clk);
  endtask : nmt

  // free-running tick allows one beat more or less per span
  task automatic beats(input int n);
    hb_seen = 0;
    repeat (n * per * TK) @(negedge clk);
    check("beat count", 75'(hb_seen >= n - 1 && hb_seen <= n + 1), 75'h1);
  endtask : beats

  // taken frames: beats are counted, all others match the oldest note
  always @(posedge clk)
  begin
    if (safe_reset === 1'b1)
      safe_seen++;
    if (got === 1'b1)
    begin
      if (got_id === hb_id && got_data !== 64'h0)
      begin
        hb_seen++;
        check("beat", {got_id, got_data}, hb_exp);
      end
      else if (exp_q.size() == 0)
        check("stray frame", {got_id, got_data}, 75'h0);
      else
        check("frame", {got_id, got_data}, exp_q.pop_front());
    end
  end

  // test sequence
  initial
  begin
    void'($urandom(15));
    node = 7'($urandom_range(126, 2));
    wn = node + 7'h01;
    per = 16'($urandom_range(4, 2));
    tmo = 16'($urandom_range(8, 6));
    repeat (5) @(posedge clk);
    exp_q.push_back({hb_id, 64'h0});
    rstn <= 1'b1;
    wait_q();
    check("state", 75'(nmt_state), 75'(CODE_PREOP));
    repeat (40) @(negedge clk);
    check("idle beats", 75'(hb_seen), 75'h0);
    fin("boot");
    slow = 1'b1;
    sdo(SDO_WRITE, PIX, 8'h00, {8'h00, per}, 24'h0, 1'b1);
    beats_on = 1'b1;
    beats(6);
    sdo(SDO_READ, PIX, 8'h00, 24'h0, {8'h00, per}, 1'b1);
    fin("producer");
    nmt(NMT_START, CODE_OPER);
    check("state", 75'(nmt_state), 75'(CODE_OPER));
    beats(4);
    nmt(NMT_STOP, CODE_STOPPED);
    check("state", 75'(nmt_state), 75'(CODE_STOPPED));
    // both writes are dropped: no reply and no effect
    sdo(SDO_WRITE, PIX, 8'h00, 24'h0, 24'h0, 1'b0);
    sdo(SDO_WRITE, CIX, 8'h01, {1'b0, wn, tmo}, 24'h0, 1'b0);
    check("monitor", 75'(cons_act), 75'h0);
    beats(4);
    nmt(NMT_PREOP, CODE_PREOP);
    fin("states");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    exp_q.push_back({hb_id, 64'h0});
    rstn <= 1'b1;
    wait_q();
    beats(3);
    for (int i = 0; i < 2; i++)
    begin
      exp_q.push_back({hb_id, 64'h0});
      safe_seen = 0;
      nmt(8'(NMT_RESET_NODE + i), CODE_PREOP);
      wait_q();
      check("safe pulse", 75'(safe_seen), 75'h1);
      beats(3);
    end
    fin("reset");
    slow = 1'b0;
    sdo(SDO_WRITE, PIX, 8'h00, 24'h0, 24'h0, 1'b1);
    beats_on = 1'b0;
    hb_seen = 0;
    nmt(NMT_START, CODE_OPER);
    sdo(SDO_WRITE, CIX, 8'h01, {1'b0, wn, tmo}, 24'h0, 1'b1);
    check("monitor", 75'(cons_act), 75'h1);
    safe_seen = 0;
    for (int i = 0; i < 8; i++)
    begin
      hbs_master_i.send(ID_HBEAT + {4'h0, wn}, {24'h0, HB_BYTE5, 24'h0, CODE_OPER});
      if (i == 0)
        sdo(SDO_READ, CIX, 8'h01, 24'h0, {1'b0, wn, tmo}, 1'b1);
      else if (i == 1)
        sdo(SDO_READ, CIX, 8'h00, 24'h0, 24'h1, 1'b1);
      else
        repeat ((tmo - 3) * TK) @(negedge clk);
    end
    check("early reset", 75'(safe_seen), 75'h0);
    exp_q.push_back({hb_id, 64'h0});
    repeat ((tmo + 2) * TK) @(negedge clk);
    check("safe pulse", 75'(safe_seen), 75'h1);
    check("state", 75'(nmt_state), 75'(CODE_PREOP));
    check("monitor", 75'(cons_act), 75'h0);
    check("no beats", 75'(hb_seen), 75'h0);
    wait_q();
    fin("consumer");
    sdo(SDO_WRITE, CIX, 8'h01, {1'b0, wn, tmo}, 24'h0, 1'b1);
    check("monitor", 75'(cons_act), 75'h1);
    sdo(SDO_WRITE, CIX, 8'h01, {1'b0, wn, 16'h0}, 24'h0, 1'b1);
    check("monitor", 75'(cons_act), 75'h0);
    safe_seen = 0;
    repeat ((tmo + 2) * TK) @(negedge clk);
    check("safe pulse", 75'(safe_seen), 75'h0);
    fin("disable");
    test_done();
  end

endmodule : testbench
`default_nettype wire
